// [core/pcid_consts.svh]
// Offsets, field positions and fixed values of the configuration header bank
`ifndef PCID_CONSTS_SVH
`define PCID_CONSTS_SVH

// Byte offsets of the fields in configuration space
`define PCID_OFF_MAKER 8'h00
`define PCID_OFF_PRODUCT 8'h02
`define PCID_OFF_REVISION 8'h08
`define PCID_OFF_CLASS 8'h09
`define PCID_OFF_SUBCLASS 8'h0a
`define PCID_OFF_BASECLASS 8'h0b
`define PCID_OFF_IO_BASE 8'h10
`define PCID_OFF_MEM_BASE 8'h14
`define PCID_OFF_MAP_BASE 8'h18

// Dword indices (byte offset divided by four) used by the decoder
`define PCID_DW_IDENT 6'h00
`define PCID_DW_CLASS 6'h02
`define PCID_DW_IO_BASE 6'h04
`define PCID_DW_MEM_BASE 6'h05
`define PCID_DW_MAP_BASE 6'h06

// Class code bytes
`define PCID_BASECLASS_BRIDGE 8'h06
`define PCID_SUBCLASS_OTHER 8'h80
`define PCID_PROG_IF_NONE 8'h00

// Revision letter of the first manufacturing release
`define PCID_REV_FIRST_LETTER "A"

// Writable address bits of each base register
`define PCID_IO_ADDR_MASK 32'hffff_ffe0
`define PCID_MEM_ADDR_MASK 32'hffff_0000
`define PCID_MAP_ADDR_MASK 32'hfff8_0000

// Read-only low bits: bit 0 of the I/O base marks I/O space
`define PCID_IO_FIXED_BITS 32'h0000_0001
`define PCID_MEM_FIXED_BITS 32'h0000_0000
`define PCID_MAP_FIXED_BITS 32'h0000_0000

// Node register block and mapping window offset widths
`define PCID_NODE_OFF_W 5
`define PCID_MAP_OFF_W 19

`endif

// [core/pcid_pkg.sv]
// Types and shared decode functions of the configuration header bank
package pcid_pkg;
	`include "pcid_consts.svh"

	typedef logic [31:0] pcid_word_t;
	typedef logic [3:0] pcid_be_t;
	typedef logic [5:0] pcid_dword_t;

	// Configuration answer sequencer
	typedef enum logic [0:0] {
		CFG_IDLE,
		CFG_ANSWER
	} pcid_cfg_state_t;

	// Expands four byte enables into a 32-bit lane mask
	function automatic pcid_word_t pcid_lane_mask(input pcid_be_t be);
		pcid_word_t m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// True when an address falls inside the window that a base register names
	function automatic logic pcid_in_window(input pcid_word_t addr, input pcid_word_t base,
		input pcid_word_t mask);
		return ((addr & mask) == (base & mask));
	endfunction
endpackage

// [core/pcid_bar.sv]
// One base address register with a fixed set of writable address bits
`timescale 1ns/1ps
`default_nettype none

module pcid_bar #(
	parameter logic [31:0] ADDR_MASK = 32'hffff_0000,
	parameter logic [31:0] FIXED_BITS = 32'h0000_0000
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Write port from the configuration decoder
	input wire logic wr_en_i,
	input wire pcid_pkg::pcid_be_t byte_en_i,
	input wire pcid_pkg::pcid_word_t wdata_i,
	// Current value as read back
	output pcid_pkg::pcid_word_t value_o
);
	import pcid_pkg::*;

	pcid_word_t base;
	pcid_word_t next_base;
	pcid_word_t wmask;

	// Only address bits in the enabled lanes take the write; sizing reads back the mask
	always_comb begin
		wmask = ADDR_MASK & pcid_lane_mask(byte_en_i);
		next_base = base;
		if (wr_en_i) begin
			next_base = (base & ~wmask) | (wdata_i & wmask);
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			base <= 32'h0000_0000;
		end else begin
			base <= next_base;
		end
	end

	// Low bits are hard-wired, so they never carry address
	assign value_o = (base & ADDR_MASK) | FIXED_BITS;
endmodule

`default_nettype wire

// [core/pcid_cfg_bank.sv]
// Configuration header identification fields, base registers and window decode
`timescale 1ns/1ps
`default_nettype none
`include "pcid_consts.svh"

// Operation
// - Manufacturer code, 16 bits, offset 0x00
// - Product code, 16 bits, offset 0x02
// - Revision at 0x08, ASCII release letter from A
// - Each later release adds one to revision
// - 24-bit class code at 0x09, three bytes
// - Base class byte 0x0B reads 0x06
// - Sub-class byte 0x0A reads 0x80
// - Programming interface byte always reads zero
// - I/O base at 0x10 places 32-byte block
// - I/O base address lives in bits 5-31
// - Memory base at 0x14 claims 64K window
// - Memory base bits 16-31, lower bits zero
// - Node registers reachable by I/O and memory
// - Mapping base at 0x18 claims 512K window
// - Mapping base bits 19-31, bits 0-18 zero
module pcid_cfg_bank #(
	parameter logic [15:0] MAKER_CODE = 16'h5a5a, // Arbitrary value
	parameter logic [15:0] PRODUCT_CODE = 16'h1234, // Arbitrary value
	parameter logic [7:0] RELEASE_INDEX = 8'h00
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Configuration cycle request
	input wire logic cfg_sel_i,
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire pcid_pkg::pcid_dword_t cfg_dword_i,
	input wire pcid_pkg::pcid_be_t cfg_byte_en_i,
	input wire pcid_pkg::pcid_word_t cfg_wdata_i,
	// Configuration answer
	output pcid_pkg::pcid_word_t cfg_rdata_o,
	output logic cfg_ack_o,
	// Bus cycle address for window decode
	input wire logic bus_io_i,
	input wire logic bus_mem_i,
	input wire pcid_pkg::pcid_word_t bus_addr_i,
	// Window hits
	output logic node_sel_o,
	output logic [`PCID_NODE_OFF_W-1:0] node_reg_o,
	output logic map_sel_o,
	output logic [`PCID_MAP_OFF_W-1:0] map_off_o
);
	import pcid_pkg::*;

	pcid_cfg_state_t state;
	pcid_cfg_state_t next_state;
	pcid_word_t rdata;
	pcid_word_t next_rdata;
	logic next_ack;
	logic take;
	logic [7:0] revision;
	logic [23:0] class_code;
	logic io_bar_wr;
	logic mem_bar_wr;
	logic map_bar_wr;
	pcid_word_t io_bar;
	pcid_word_t mem_bar;
	pcid_word_t map_bar;
	pcid_word_t row;
	logic node_sel;
	logic next_node_sel;
	logic [`PCID_NODE_OFF_W-1:0] node_reg;
	logic [`PCID_NODE_OFF_W-1:0] next_node_reg;
	logic map_sel;
	logic next_map_sel;
	logic [`PCID_MAP_OFF_W-1:0] map_off;
	logic [`PCID_MAP_OFF_W-1:0] next_map_off;

	// Checks below share the bus clock and stay quiet while reset is held
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	// Release letter steps by one per manufacturing release
	assign revision = 8'(`PCID_REV_FIRST_LETTER) + RELEASE_INDEX;

	// Base class on top, sub-class in the middle, interface byte unsupported
	assign class_code = {`PCID_BASECLASS_BRIDGE, `PCID_SUBCLASS_OTHER,
		`PCID_PROG_IF_NONE};

	// Identification bytes as they leave on a read of the class dword
	rev_value_a: assert property (take && cfg_rd_i
		&& cfg_dword_i == `PCID_DW_CLASS && cfg_byte_en_i[0]
		|=> cfg_rdata_o[7:0] == 8'(`PCID_REV_FIRST_LETTER) + RELEASE_INDEX)
		else $error("revision not release letter");
	class_read_a: assert property (take && cfg_rd_i
		&& cfg_dword_i == `PCID_DW_CLASS && cfg_byte_en_i == 4'hf
		|=> cfg_rdata_o[31:8] == 24'h068000)
		else $error("class code wrong");
	prog_if_a: assert property (take && cfg_rd_i && cfg_dword_i == `PCID_DW_CLASS
		|=> cfg_rdata_o[15:8] == 8'h00)
		else $error("programming interface byte not zero");

	// A request is taken only when idle, so back-to-back cycles see one answer each
	assign take = cfg_sel_i && (cfg_rd_i || cfg_wr_i) && (state == CFG_IDLE);

	// One answer pulse per taken request, none for other cards' cycles
	ack_timing_a: assert property (take |=> cfg_ack_o ##1 !cfg_ack_o)
		else $error("ack not a single cycle after request");
	ack_cause_a: assert property (cfg_ack_o |->
		$past(cfg_sel_i) && $past(state) == CFG_IDLE)
		else $error("ack without a selected request");
	unsel_quiet_a: assert property (!cfg_sel_i |=> !cfg_ack_o)
		else $error("ack for an unselected cycle");
	answer_busy_a: assert property (state == CFG_ANSWER |=> !cfg_ack_o)
		else $error("request taken during the answer cycle");

	// Base register writes come from configuration software assigning windows only
	assign io_bar_wr = take && cfg_wr_i && (cfg_dword_i == `PCID_DW_IO_BASE);
	assign mem_bar_wr = take && cfg_wr_i && (cfg_dword_i == `PCID_DW_MEM_BASE);
	assign map_bar_wr = take && cfg_wr_i && (cfg_dword_i == `PCID_DW_MAP_BASE);

	// I/O base: address bits 5 and up, bit 0 marks I/O space
	pcid_bar #(
		.ADDR_MASK(`PCID_IO_ADDR_MASK),
		.FIXED_BITS(`PCID_IO_FIXED_BITS)
	) u_io_bar (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.wr_en_i(io_bar_wr),
		.byte_en_i(cfg_byte_en_i),
		.wdata_i(cfg_wdata_i),
		.value_o(io_bar)
	);

	// Memory base of the node registers, 64K granularity
	pcid_bar #(
		.ADDR_MASK(`PCID_MEM_ADDR_MASK),
		.FIXED_BITS(`PCID_MEM_FIXED_BITS)
	) u_mem_bar (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.wr_en_i(mem_bar_wr),
		.byte_en_i(cfg_byte_en_i),
		.wdata_i(cfg_wdata_i),
		.value_o(mem_bar)
	);

	// Mapping window base, 512K granularity
	pcid_bar #(
		.ADDR_MASK(`PCID_MAP_ADDR_MASK),
		.FIXED_BITS(`PCID_MAP_FIXED_BITS)
	) u_map_bar (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.wr_en_i(map_bar_wr),
		.byte_en_i(cfg_byte_en_i),
		.wdata_i(cfg_wdata_i),
		.value_o(map_bar)
	);

	// Hard-wired low bits can never carry address
	io_low_a: assert property (io_bar[4:0] == 5'h01)
		else $error("io base low bits wrong");
	mem_low_a: assert property (mem_bar[15:0] == 16'h0000)
		else $error("memory base low bits not zero");
	map_low_a: assert property (map_bar[18:0] == 19'h00000)
		else $error("mapping base low bits not zero");
	// A full-width write lands on exactly the address bits of each base
	io_write_a: assert property (io_bar_wr && cfg_byte_en_i == 4'hf
		|=> io_bar == (($past(cfg_wdata_i) & 32'hffff_ffe0) | 32'h0000_0001))
		else $error("io base write lost");
	bar_write_a: assert property (mem_bar_wr && cfg_byte_en_i == 4'hf
		|=> mem_bar == ($past(cfg_wdata_i) & 32'hffff_0000))
		else $error("memory base write lost");
	map_write_a: assert property (map_bar_wr && cfg_byte_en_i == 4'hf
		|=> map_bar == ($past(cfg_wdata_i) & 32'hfff8_0000))
		else $error("mapping base write lost");

	// Row select; unlisted dwords read as zero
	always_comb begin
		case (cfg_dword_i)
			`PCID_DW_IDENT: row = {PRODUCT_CODE, MAKER_CODE};
			`PCID_DW_CLASS: row = {class_code, revision};
			`PCID_DW_IO_BASE: row = io_bar;
			`PCID_DW_MEM_BASE: row = mem_bar;
			`PCID_DW_MAP_BASE: row = map_bar;
			default: row = 32'h0000_0000;
		endcase
	end

	// Answer sequencer: one answer cycle per taken request
	always_comb begin
		next_state = state;
		next_rdata = rdata;
		next_ack = 1'b0;
		case (state)
			CFG_IDLE: begin
				if (take) begin
					next_state = CFG_ANSWER;
					next_ack = 1'b1;
					// Lanes not enabled return zero so narrow reads stay clean
					next_rdata = cfg_rd_i ? (row & pcid_lane_mask(cfg_byte_en_i))
						: 32'h0000_0000;
				end
			end
			CFG_ANSWER: begin
				next_state = CFG_IDLE;
			end
			default: begin
				next_state = CFG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state <= CFG_IDLE;
			rdata <= 32'h0000_0000;
			cfg_ack_o <= 1'b0;
		end else begin
			state <= next_state;
			rdata <= next_rdata;
			cfg_ack_o <= next_ack;
		end
	end

	assign cfg_rdata_o = rdata;

	// Answer data: full identity word, clean disabled lanes, empty write answers
	ident_read_a: assert property (take && cfg_rd_i
		&& cfg_dword_i == `PCID_DW_IDENT && cfg_byte_en_i == 4'hf
		|=> cfg_rdata_o == {PRODUCT_CODE, MAKER_CODE})
		else $error("identity dword wrong");
	lane_zero_a: assert property (take && cfg_rd_i && !cfg_byte_en_i[0]
		|=> cfg_rdata_o[7:0] == 8'h00)
		else $error("disabled lane not zero");
	write_zero_a: assert property (take && !cfg_rd_i
		|=> cfg_rdata_o == 32'h0000_0000)
		else $error("write answer carries data");

	// Window decode: both node windows lead to the same five-bit register index
	always_comb begin
		next_node_sel = 1'b0;
		next_node_reg = node_reg;
		next_map_sel = 1'b0;
		next_map_off = map_off;
		// I/O space compares the full 27-bit block base
		if (bus_io_i && pcid_in_window(bus_addr_i, io_bar, `PCID_IO_ADDR_MASK)) begin
			next_node_sel = 1'b1;
			next_node_reg = bus_addr_i[`PCID_NODE_OFF_W-1:0];
		end
		// Memory hits past the first 32 bytes of the 64K claim select nothing
		if (bus_mem_i && pcid_in_window(bus_addr_i, mem_bar, `PCID_MEM_ADDR_MASK)
			&& (bus_addr_i[15:`PCID_NODE_OFF_W] == 11'h000)) begin
			next_node_sel = 1'b1;
			next_node_reg = bus_addr_i[`PCID_NODE_OFF_W-1:0];
		end
		// Whole 512K claim is decoded; all 19 offset bits reach map_off
		if (bus_mem_i && pcid_in_window(bus_addr_i, map_bar, `PCID_MAP_ADDR_MASK)) begin
			next_map_sel = 1'b1;
			next_map_off = bus_addr_i[`PCID_MAP_OFF_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			node_sel <= 1'b0;
			node_reg <= 5'h00;
			map_sel <= 1'b0;
			map_off <= 19'h00000;
		end else begin
			node_sel <= next_node_sel;
			node_reg <= next_node_reg;
			map_sel <= next_map_sel;
			map_off <= next_map_off;
		end
	end

	assign node_sel_o = node_sel;
	assign node_reg_o = node_reg;
	assign map_sel_o = map_sel;
	assign map_off_o = map_off;

	// Window hits carry the offset of the address that caused them
	node_index_a: assert property (node_sel_o
		|-> node_reg_o == $past(bus_addr_i[4:0]))
		else $error("node index not from address");
	map_index_a: assert property (map_sel_o
		|-> map_off_o == $past(bus_addr_i[18:0]))
		else $error("mapping offset not from address");
	mem_far_a: assert property (bus_mem_i && !bus_io_i
		&& bus_addr_i[15:5] != 11'h000 |=> !node_sel_o)
		else $error("node hit past the first 32 bytes");

	// Main scenarios worth seeing at least once
	read_ident_c: cover property (take && cfg_rd_i && cfg_dword_i == 6'h00);
	size_bar_c: cover property (io_bar_wr && cfg_wdata_i == 32'hffff_ffff);
	node_io_c: cover property (node_sel_o && $past(bus_io_i));
	node_mem_c: cover property (node_sel_o && $past(bus_mem_i));
	map_hit_c: cover property (map_sel_o);
endmodule

`default_nettype wire

// [sim/pcid_host_model.sv]
// Host bridge model that issues configuration cycles to the bank
`timescale 1ns/1ps
`default_nettype none

module pcid_host_model (
	// Clock
	input wire logic clk_sys_i,
	// Configuration request
	output logic cfg_sel_o,
	output logic cfg_rd_o,
	output logic cfg_wr_o,
	output pcid_pkg::pcid_dword_t cfg_dword_o,
	output pcid_pkg::pcid_be_t cfg_byte_en_o,
	output pcid_pkg::pcid_word_t cfg_wdata_o,
	// Configuration answer
	input wire pcid_pkg::pcid_word_t cfg_rdata_i,
	input wire logic cfg_ack_i
);
	import pcid_pkg::*;

	// Idle bus at time zero
	initial begin
		{cfg_sel_o, cfg_rd_o, cfg_wr_o} = 3'h0;
		{cfg_dword_o, cfg_byte_en_o, cfg_wdata_o} = '0;
	end

	// One request, held until the answering edge, then released
	task automatic xfer(input logic sel, input logic wr, input pcid_dword_t dw,
		input pcid_be_t be, input pcid_word_t wd, output pcid_word_t rd, output logic ok);
		ok = 1'b0;
		rd = '0;
		@(negedge clk_sys_i);
		{cfg_sel_o, cfg_rd_o, cfg_wr_o} = {sel, !wr, wr};
		{cfg_dword_o, cfg_byte_en_o, cfg_wdata_o} = {dw, be, wd};
		// Bounded wait: an unselected request never gets an answer
		for (int n = 0; n < 4 && !ok; n++) begin
			@(posedge clk_sys_i);
			ok = (cfg_ack_i === 1'b1);
			rd = cfg_rdata_i;
		end
		@(negedge clk_sys_i);
		// Control lines drop to zero; the other released lines show the inverse so stale values cannot pass
		{cfg_sel_o, cfg_rd_o, cfg_wr_o} = 3'h0;
		{cfg_dword_o, cfg_byte_en_o, cfg_wdata_o} = ~{dw, be, wd};
	endtask

	// Window base as a driver must use it: read only, never written
	task automatic base(input pcid_dword_t dw, output pcid_word_t b);
		pcid_word_t w;
		logic ok;
		xfer(1'b1, 1'b0, dw, 4'hf, 32'h0, w, ok);
		b = w & 32'hffff_fff0;
	endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the configuration header bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import pcid_pkg::*;
	localparam logic [15:0] MAKER = 16'hc3a5; // Arbitrary value
	localparam logic [15:0] PRODUCT = 16'h7e11; // Arbitrary value
	localparam logic [7:0] REL = 8'h02;
	localparam logic [7:0] REV = "A" + REL;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic bus_io_i = 1'b0;
	logic bus_mem_i = 1'b0;
	pcid_word_t bus_addr_i = '0;
	logic cfg_sel, cfg_rd, cfg_wr, cfg_ack, node_sel_o, map_sel_o;
	pcid_dword_t cfg_dword;
	pcid_be_t cfg_be;
	pcid_word_t cfg_wdata, cfg_rdata;
	logic [4:0] node_reg_o;
	logic [18:0] map_off_o;
	int n_errors = 0;
	int tests_run = 0;

	// 50 MHz clock
	always #10 clk_sys_i = ~clk_sys_i;

	pcid_cfg_bank #(.MAKER_CODE(MAKER), .PRODUCT_CODE(PRODUCT), .RELEASE_INDEX(REL))
		pcid_cfg_bank_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_sel_i(cfg_sel),
		.cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr), .cfg_dword_i(cfg_dword),
		.cfg_byte_en_i(cfg_be), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
		.cfg_ack_o(cfg_ack), .bus_io_i(bus_io_i), .bus_mem_i(bus_mem_i),
		.bus_addr_i(bus_addr_i), .node_sel_o(node_sel_o), .node_reg_o(node_reg_o),
		.map_sel_o(map_sel_o), .map_off_o(map_off_o));

	pcid_host_model pcid_host_model_inst (.clk_sys_i(clk_sys_i), .cfg_sel_o(cfg_sel),
		.cfg_rd_o(cfg_rd), .cfg_wr_o(cfg_wr), .cfg_dword_o(cfg_dword),
		.cfg_byte_en_o(cfg_be), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata),
		.cfg_ack_i(cfg_ack));

	task automatic chk_word(input string what, input pcid_word_t exp, input pcid_word_t got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Identification words, lane selection and an unselected request
	task automatic t_ident();
		pcid_word_t w;
		logic ok;
		pcid_host_model_inst.xfer(1'b1, 1'b0, 6'h00, 4'hf, 32'h0, w, ok);
		chk_bit("ident ack", 1'b1, ok);
		chk_word("ident", {PRODUCT, MAKER}, w);
		pcid_host_model_inst.xfer(1'b1, 1'b0, 6'h00, 4'h3, 32'h0, w, ok);
		chk_word("ident low lanes", {16'h0000, MAKER}, w);
		pcid_host_model_inst.xfer(1'b0, 1'b0, 6'h00, 4'hf, 32'h0, w, ok);
		chk_bit("unselected ack", 1'b0, ok);
	endtask

	// Class and revision word survives a write attempt unchanged
	task automatic t_class();
		pcid_word_t w;
		logic ok;
		pcid_host_model_inst.xfer(1'b1, 1'b1, 6'h02, 4'hf, 32'hffff_ffff, w, ok);
		pcid_host_model_inst.xfer(1'b1, 1'b0, 6'h02, 4'hf, 32'h0, w, ok);
		chk_word("revision", {24'h0, REV}, {24'h0, w[7:0]});
		chk_word("class", 32'h0680_0000, {w[31:16], 16'h0});
		chk_word("interface byte", 32'h0, {24'h0, w[15:8]});
	endtask

	// Reset values, then sizing writes and a one-lane write
	task automatic t_bars();
		pcid_word_t rst[3] = '{32'h0000_0001, 32'h0, 32'h0};
		pcid_word_t ones[3] = '{32'hffff_ffe1, 32'hffff_0000, 32'hfff8_0000};
		pcid_word_t w;
		logic ok;
		for (int i = 0; i < 3; i++) begin
			pcid_host_model_inst.xfer(1'b1, 1'b0, 6'(4 + i), 4'hf, 32'h0, w, ok);
			chk_word("base reset", rst[i], w);
			pcid_host_model_inst.xfer(1'b1, 1'b1, 6'(4 + i), 4'hf, 32'hffff_ffff, w, ok);
			pcid_host_model_inst.xfer(1'b1, 1'b0, 6'(4 + i), 4'hf, 32'h0, w, ok);
			chk_word("base sized", ones[i], w);
		end
		pcid_host_model_inst.xfer(1'b1, 1'b1, 6'h04, 4'h1, 32'h0, w, ok);
		pcid_host_model_inst.xfer(1'b1, 1'b0, 6'h04, 4'hf, 32'h0, w, ok);
		chk_word("io base lane", 32'hffff_ff01, w);
	endtask

	// One bus address, decode judged one cycle later
	task automatic probe(input logic io, input logic mem, input pcid_word_t a,
		input logic en, input logic [4:0] er, input logic em, input logic [18:0] eo);
		@(negedge clk_sys_i);
		{bus_io_i, bus_mem_i, bus_addr_i} = {io, mem, a};
		@(negedge clk_sys_i);
		chk_bit("node hit", en, node_sel_o);
		if (en) chk_word("node offset", {27'h0, er}, {27'h0, node_reg_o});
		chk_bit("map hit", em, map_sel_o);
		if (em) chk_word("map offset", {13'h0, eo}, {13'h0, map_off_o});
	endtask

	// Assigned windows decoded through both spaces
	task automatic t_window();
		pcid_word_t w, io, mb, pb;
		logic ok;
		pcid_host_model_inst.xfer(1'b1, 1'b1, 6'h04, 4'hf, 32'h0000_1240, w, ok);
		pcid_host_model_inst.xfer(1'b1, 1'b1, 6'h05, 4'hf, 32'habcd_0000, w, ok);
		pcid_host_model_inst.xfer(1'b1, 1'b1, 6'h06, 4'hf, 32'h8200_0000, w, ok);
		pcid_host_model_inst.base(6'h04, io);
		pcid_host_model_inst.base(6'h05, mb);
		pcid_host_model_inst.base(6'h06, pb);
		chk_word("io base", 32'h0000_1240, io);
		probe(1'b1, 1'b0, io + 32'hc, 1'b1, 5'h0c, 1'b0, 19'h0);
		probe(1'b1, 1'b0, io + 32'h20, 1'b0, 5'h0, 1'b0, 19'h0);
		probe(1'b0, 1'b1, mb + 32'hc, 1'b1, 5'h0c, 1'b0, 19'h0);
		probe(1'b0, 1'b1, mb + 32'h20, 1'b0, 5'h0, 1'b0, 19'h0);
		probe(1'b0, 1'b1, pb + 32'h7fffc, 1'b0, 5'h0, 1'b1, 19'h7fffc);
		probe(1'b0, 1'b1, pb + 32'h80000, 1'b0, 5'h0, 1'b0, 19'h0);
		probe(1'b0, 1'b0, 32'h0, 1'b0, 5'h0, 1'b0, 19'h0);
	endtask

	// Main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(negedge clk_sys_i);
		reset_i = 1'b0;
		t_ident();
		t_class();
		t_bars();
		t_window();
		stop_test();
	end

	// Watchdog: 2000 cycles, far beyond the hundred or so cycles the tests need
	initial begin
		#40000;
		n_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
